// >>> core/lfva_pkg.sv
/*
  Constants and carrier types for the line buffer block.
  Assumes a single 100 MHz system clock and an AXI4-Lite host.
*/
//
// Overview of operation
// - Two-bit field picks video, ASI, ancillary, bypass
// - Bypass ignores both pins; ASI ignores processing
// - Read and write sides run independently
// - 2048 entries of ten data, five side bits
// - Video-select high, ASI low defaults mode video
// - ASI-select high defaults mode to ASI
// - Video writes first active pixel at zero
// - Video timing flags stored, aligned to data
// - Write side follows pixel strobe, line timing
// - Video words leave on read-clock rising edge
// - Read-reset fall points reader at first SAV zero word
// - Ancillary detect aligned with read data
// - ASI bytes written with sync, error flags
// - No ASI writes while stuffing sync is high
// - ASI reads by read clock, ignores reset
// - Empty rises when reader meets writer
// - Empty offset holds empty until writes exceed
// - Full rises when writer meets reader
// - Full offset holds full until reads exceed
// - Bypass keeps buffer static, passes input

package lfva_pkg;

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int DEPTH = 2048;
  localparam int DATA_W = 10;
  localparam int SIDE_W = 5;
  localparam int OFF_W = 10;
  localparam int ASI_DATA_W = 8;
  // SAV words 000,000,XYZ sit just below address zero
  localparam int SAV_LEAD = 3;

  // ----------------------------------------
  // Modes
  // ----------------------------------------
  localparam logic [1:0] MODE_VIDEO = 2'h0;
  localparam logic [1:0] MODE_ASI = 2'h1;
  localparam logic [1:0] MODE_ANC = 2'h2;
  localparam logic [1:0] MODE_BYPASS = 2'h3;
  localparam logic [1:0] MODE_RST = 2'h3;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_EOFF = 4'h4;
  localparam logic [3:0] ADDR_FOFF = 4'h8;
  localparam logic [3:0] ADDR_STAT = 4'hC;
  localparam int CTRL_MODE_LSB = 0;
  localparam int STAT_EMPTY = 0;
  localparam int STAT_FULL = 1;
  localparam int STAT_BUF = 2;
  localparam int STAT_MODE_LSB = 4;
  localparam int STAT_WPTR_LSB = 16;
  localparam logic [9:0] EOFF_RST = 10'h000;
  localparam logic [9:0] FOFF_RST = 10'h000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Pins and ASI side layout
  // ----------------------------------------
  localparam int PIN_RDCLK = 0;
  localparam int PIN_RDRST = 1;
  localparam int PIN_BUF = 2;
  localparam int PIN_PROC = 3;
  localparam int PIN_VID = 4;
  localparam int PIN_ASI = 5;
  localparam int PIN_N = 6;
  localparam logic [5:0] PIN_RST = 6'h02;
  localparam int ASI_SYNC_BIT = 4;
  localparam int ASI_ERR_BIT = 3;

  typedef struct packed {
    logic h;
    logic v;
    logic f;
    logic err_pkt;
    logic anc;
  } lfva_side_s;

  typedef struct packed {
    lfva_side_s side;
    logic [DATA_W-1:0] data;
  } lfva_entry_s;

endpackage : lfva_pkg

// >>> core/lfva_top.sv
/*
  Line buffer with video, ASI, ancillary and bypass modes.
  Assumes write-side words arrive on CLK with a strobe from the
  decoder; read clock, read reset and mode pins come from outside.
*/
`timescale 1ns/1ns
`default_nettype none

module lfva_top #(
  parameter int DEPTH = lfva_pkg::DEPTH
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // AXI4-Lite slave
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [3:0] S_AXI_ARADDR,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  // Device pins
  input wire logic BUFFER_ENABLE_PIN,
  input wire logic PROCESSING_ENABLE_PIN,
  input wire logic VIDEO_DECODE_SELECT_PIN,
  input wire logic ASI_SELECT_PIN,
  input wire logic RD_CLK,
  input wire logic RD_RESET_N,
  // Decoded write side
  input wire logic WR_VALID,
  input wire logic WR_LINE_START,
  input wire lfva_pkg::lfva_entry_s WR_WORD,
  input wire logic STUFFING_SYNC_FLAG,
  input wire logic CODE_WORD_ERROR_FLAG,
  // Read side
  output lfva_pkg::lfva_entry_s RD_WORD,
  output logic FIFO_EMPTY,
  output logic FIFO_FULL
);

  localparam int AW = $clog2(DEPTH);
  localparam int EW = lfva_pkg::DATA_W + lfva_pkg::SIDE_W;
  localparam logic [AW-1:0] SAV_ADDR = AW'(DEPTH - lfva_pkg::SAV_LEAD);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic reg_hit(input logic [3:0] a);
    return a == lfva_pkg::ADDR_CTRL || a == lfva_pkg::ADDR_EOFF ||
      a == lfva_pkg::ADDR_FOFF || a == lfva_pkg::ADDR_STAT;
  endfunction : reg_hit

  function automatic logic [31:0] merge(input logic [31:0] o,
    input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [1:0] dflt_mode(input logic vid, input logic asi);
    if (asi) begin
      return lfva_pkg::MODE_ASI;
    end
    if (vid) begin
      return lfva_pkg::MODE_VIDEO;
    end
    return lfva_pkg::MODE_BYPASS;
  endfunction : dflt_mode

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // A change counts once stages two and three agree
  logic [lfva_pkg::PIN_N-1:0] pin_raw;
  logic [lfva_pkg::PIN_N-1:0] pin_f;
  assign pin_raw = {ASI_SELECT_PIN, VIDEO_DECODE_SELECT_PIN,
    PROCESSING_ENABLE_PIN, BUFFER_ENABLE_PIN, RD_RESET_N, RD_CLK};

  generate
    for (genvar g = 0; g < lfva_pkg::PIN_N; g++) begin : g_sync
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic f_reg;
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          s1_reg <= lfva_pkg::PIN_RST[g];
          s2_reg <= lfva_pkg::PIN_RST[g];
          s3_reg <= lfva_pkg::PIN_RST[g];
          f_reg <= lfva_pkg::PIN_RST[g];
        end else begin
          s1_reg <= pin_raw[g];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          f_reg <= (s2_reg == s3_reg) ? s3_reg : f_reg;
        end
      end
      assign pin_f[g] = f_reg;
    end
  endgenerate

  logic [lfva_pkg::PIN_N-1:0] pin_d_reg;
  logic init_reg;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_d_reg <= lfva_pkg::PIN_RST;
      init_reg <= 1'b1;
    end else begin
      pin_d_reg <= pin_f;
      init_reg <= 1'b0;
    end
  end

  wire rd_rise = pin_f[lfva_pkg::PIN_RDCLK] & ~pin_d_reg[lfva_pkg::PIN_RDCLK];
  wire rd_rst_fall = ~pin_f[lfva_pkg::PIN_RDRST] & pin_d_reg[lfva_pkg::PIN_RDRST];
  wire sel_chg = init_reg ||
    pin_f[lfva_pkg::PIN_VID] != pin_d_reg[lfva_pkg::PIN_VID] ||
    pin_f[lfva_pkg::PIN_ASI] != pin_d_reg[lfva_pkg::PIN_ASI];

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  logic aw_full_reg;
  logic w_full_reg;
  logic [3:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [1:0] mode_reg;
  logic [lfva_pkg::OFF_W-1:0] eoff_reg;
  logic [lfva_pkg::OFF_W-1:0] foff_reg;

  assign S_AXI_AWREADY = ~aw_full_reg & ~bvalid_reg;
  assign S_AXI_WREADY = ~w_full_reg & ~bvalid_reg;
  assign S_AXI_ARREADY = ~rvalid_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;

  wire aw_hs = S_AXI_AWVALID & S_AXI_AWREADY;
  wire w_hs = S_AXI_WVALID & S_AXI_WREADY;
  wire ar_hs = S_AXI_ARVALID & S_AXI_ARREADY;
  wire aw_have = aw_full_reg | aw_hs;
  wire w_have = w_full_reg | w_hs;
  wire wr_do = aw_have & w_have;
  wire [3:0] wa = aw_full_reg ? aw_addr_reg : S_AXI_AWADDR;
  wire [31:0] wd = w_full_reg ? w_data_reg : S_AXI_WDATA;
  wire [3:0] ws = w_full_reg ? w_strb_reg : S_AXI_WSTRB;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= lfva_pkg::RESP_OKAY;
    end else begin
      aw_full_reg <= aw_have & ~wr_do;
      w_full_reg <= w_have & ~wr_do;
      aw_addr_reg <= aw_hs ? S_AXI_AWADDR : aw_addr_reg;
      w_data_reg <= w_hs ? S_AXI_WDATA : w_data_reg;
      w_strb_reg <= w_hs ? S_AXI_WSTRB : w_strb_reg;
      bvalid_reg <= wr_do | (bvalid_reg & ~S_AXI_BREADY);
      if (wr_do) begin
        bresp_reg <= reg_hit(wa) ? lfva_pkg::RESP_OKAY : lfva_pkg::RESP_SLVERR;
      end
    end
  end

  // Host write beats a pin default landing in the same cycle
  wire ctrl_we = wr_do & (wa == lfva_pkg::ADDR_CTRL) & ws[0];
  wire [31:0] ctrl_m = merge({30'h0, mode_reg}, wd, ws);
  wire [31:0] eoff_m = merge({22'h0, eoff_reg}, wd, ws);
  wire [31:0] foff_m = merge({22'h0, foff_reg}, wd, ws);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_reg <= lfva_pkg::MODE_RST;
      eoff_reg <= lfva_pkg::EOFF_RST;
      foff_reg <= lfva_pkg::FOFF_RST;
    end else begin
      if (ctrl_we) begin
        mode_reg <= ctrl_m[lfva_pkg::CTRL_MODE_LSB +: 2];
      end else if (sel_chg) begin
        mode_reg <= dflt_mode(pin_f[lfva_pkg::PIN_VID], pin_f[lfva_pkg::PIN_ASI]);
      end
      if (wr_do && wa == lfva_pkg::ADDR_EOFF) begin
        eoff_reg <= eoff_m[lfva_pkg::OFF_W-1:0];
      end
      if (wr_do && wa == lfva_pkg::ADDR_FOFF) begin
        foff_reg <= foff_m[lfva_pkg::OFF_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // Effective mode
  // ----------------------------------------
  wire pen = pin_f[lfva_pkg::PIN_BUF];
  wire ppr = pin_f[lfva_pkg::PIN_PROC];
  wire is_vid = mode_reg == lfva_pkg::MODE_VIDEO & pen & ppr;
  wire is_asi = mode_reg == lfva_pkg::MODE_ASI & pen;
  wire is_anc = mode_reg == lfva_pkg::MODE_ANC & pen & ppr;
  // Any other combination falls back to bypass
  wire is_byp = ~(is_vid | is_asi | is_anc);

  // ----------------------------------------
  // Storage and write side
  // ----------------------------------------
  logic [EW-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;

  wire wr_vid = is_vid & WR_VALID;
  wire wr_asi = is_asi & WR_VALID & ~STUFFING_SYNC_FLAG;
  wire we = wr_vid | wr_asi;
  wire [AW-1:0] waddr = (wr_vid & WR_LINE_START) ? AW'(0) : wr_ptr_reg;
  lfva_pkg::lfva_entry_s asi_word;
  always_comb begin
    asi_word = '0;
    asi_word.data[lfva_pkg::ASI_DATA_W-1:0] = WR_WORD.data[lfva_pkg::ASI_DATA_W-1:0];
    asi_word[lfva_pkg::DATA_W + lfva_pkg::ASI_SYNC_BIT] = STUFFING_SYNC_FLAG;
    asi_word[lfva_pkg::DATA_W + lfva_pkg::ASI_ERR_BIT] = CODE_WORD_ERROR_FLAG;
  end
  // Video keeps H, V, F and detect flags beside each sample
  wire [EW-1:0] wdata = wr_vid ? WR_WORD : asi_word;

  always_ff @(posedge CLK) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_ptr_reg <= '0;
    end else if (we) begin
      wr_ptr_reg <= waddr + AW'(1);
    end
  end

  // ----------------------------------------
  // Read side
  // ----------------------------------------
  wire rd_fire = rd_rise & (is_vid | is_asi);
  wire rd_sav = rd_rst_fall & is_vid;
  wire [EW-1:0] rd_q = mem[rd_ptr_reg];

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_ptr_reg <= '0;
    end else if (rd_sav) begin
      rd_ptr_reg <= SAV_ADDR;
    end else if (rd_fire) begin
      rd_ptr_reg <= rd_ptr_reg + AW'(1);
    end
  end

  // Bypass output follows the write strobe, buffer untouched
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RD_WORD <= '0;
    end else if (is_byp & WR_VALID) begin
      RD_WORD <= WR_WORD;
    end else if (rd_fire) begin
      RD_WORD <= rd_q;
    end
  end

  // ----------------------------------------
  // Empty and full flags
  // ----------------------------------------
  logic last_wr_reg;
  logic [AW:0] ecnt_reg;
  logic [AW:0] fcnt_reg;
  wire eq = wr_ptr_reg == rd_ptr_reg;
  wire e_set = eq & ~last_wr_reg;
  wire f_set = eq & last_wr_reg;
  wire e_clr = ecnt_reg > {1'b0, eoff_reg};
  wire f_clr = fcnt_reg > {1'b0, foff_reg};

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      last_wr_reg <= 1'b0;
      FIFO_EMPTY <= 1'b0;
      FIFO_FULL <= 1'b0;
      ecnt_reg <= '0;
      fcnt_reg <= '0;
    end else begin
      if (we != rd_fire) begin
        last_wr_reg <= we;
      end
      // Set wins over the offset clear
      FIFO_EMPTY <= e_set | (FIFO_EMPTY & ~e_clr);
      FIFO_FULL <= f_set | (FIFO_FULL & ~f_clr);
      // A move on the matching edge already counts as the first one
      ecnt_reg <= e_set ? (AW+1)'(we) : ecnt_reg + (AW+1)'(FIFO_EMPTY & we);
      fcnt_reg <= f_set ? (AW+1)'(rd_fire) : fcnt_reg + (AW+1)'(FIFO_FULL & rd_fire);
    end
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  logic [31:0] stat;
  always_comb begin
    stat = '0;
    stat[lfva_pkg::STAT_EMPTY] = FIFO_EMPTY;
    stat[lfva_pkg::STAT_FULL] = FIFO_FULL;
    stat[lfva_pkg::STAT_BUF] = ~is_byp;
    stat[lfva_pkg::STAT_MODE_LSB +: 2] = mode_reg;
    stat[lfva_pkg::STAT_WPTR_LSB +: AW] = wr_ptr_reg;
  end
  wire [31:0] rd_mux = (S_AXI_ARADDR == lfva_pkg::ADDR_CTRL) ? {30'h0, mode_reg} :
    (S_AXI_ARADDR == lfva_pkg::ADDR_EOFF) ? {22'h0, eoff_reg} :
    (S_AXI_ARADDR == lfva_pkg::ADDR_FOFF) ? {22'h0, foff_reg} :
    (S_AXI_ARADDR == lfva_pkg::ADDR_STAT) ? stat : 32'h0;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= lfva_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= reg_hit(S_AXI_ARADDR) ? lfva_pkg::RESP_OKAY : lfva_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_sav_load;
    rd_sav ##1 (rd_ptr_reg == SAV_ADDR);
  endsequence
  sequence s_first_read;
    rd_fire ##1 (RD_WORD == $past(rd_q));
  endsequence

  chk_asi_stuff_skip: assert property (
    is_asi && STUFFING_SYNC_FLAG |=> $stable(wr_ptr_reg) || $past(rd_sav))
    else $error("write taken during stuffing sync");
  chk_bypass_static: assert property (is_byp |-> !we)
    else $error("buffer written in bypass");
  chk_read_edge: assert property (rd_fire && !is_byp |-> s_first_read)
    else $error("read word not taken from buffer");
  chk_rdrst_sav: assert property (rd_sav |-> s_sav_load)
    else $error("read reset did not land on SAV");
  chk_asi_no_rdrst: assert property (
    is_asi && rd_rst_fall && !rd_fire |=> $stable(rd_ptr_reg))
    else $error("read reset acted in ASI mode");
  chk_line_zero: assert property (wr_vid && WR_LINE_START |=> wr_ptr_reg == AW'(1))
    else $error("line start not written at zero");
  chk_empty_set: assert property (e_set |=> FIFO_EMPTY)
    else $error("empty missed pointer match");
  chk_empty_hold: assert property (
    FIFO_EMPTY && !e_clr |=> FIFO_EMPTY)
    else $error("empty dropped inside offset");
  chk_full_set: assert property (f_set |=> FIFO_FULL)
    else $error("full missed pointer match");
  chk_full_zero: assert property (
    FIFO_FULL && foff_reg == 10'h000 && !f_set && fcnt_reg != '0 |=> !FIFO_FULL)
    else $error("full stayed up with zero offset");
  chk_asi_default: assert property (
    $rose(pin_f[lfva_pkg::PIN_ASI]) && !ctrl_we |=> mode_reg == lfva_pkg::MODE_ASI)
    else $error("ASI pin did not default mode");

endmodule : lfva_top

`default_nettype wire

// >>> testbench/lfva_reader.sv
/*
  Read-side partner: makes the burst read clock and the read reset.
  Assumes the bench calls its tasks; the read clock rests low between bursts.
*/
`timescale 1ns/1ns
`default_nettype none

module lfva_reader (
  // Read side pins
  output logic rd_clk,
  output logic rd_reset_n
);
  initial begin
    rd_clk = 1'b0;
    rd_reset_n = 1'b1;
  end

  // ----------------------------------------
  // Burst clock
  // ----------------------------------------
  // Whole 160 ns periods only, so no runt pulse reaches the buffer
  task automatic pulse(input int n);
    for (int i = 0; i < n; i++) begin
      #3;
      rd_clk = 1'b1;
      #80;
      rd_clk = 1'b0;
      #77;
    end
  endtask : pulse

  // ----------------------------------------
  // Read reset
  // ----------------------------------------
  // Low for half a read-clock period, while the clock rests
  task automatic rst_pulse();
    #7;
    rd_reset_n = 1'b0;
    #80;
    rd_reset_n = 1'b1;
    #73;
  endtask : rst_pulse
endmodule : lfva_reader

`default_nettype wire

// >>> testbench/lfva_top_tb.sv
/*
  Self-checking bench for the line buffer: bypass, modes, ASI flags, video.
  Assumes the reader partner and a buffer depth lowered to 64.
*/
`timescale 1ns/1ns
`default_nettype none

module lfva_top_tb;
  localparam int DEPTH = 64;
  logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp;
  logic buf_en, proc_en, vid_sel, asi_sel, rd_clk, rd_reset_n;
  logic wr_valid, wr_start, sync_flag, err_flag, empty, full;
  lfva_pkg::lfva_entry_s wr_word, rd_word;
  int errors, check_count;
  logic [14:0] seq [6] = '{15'h0400, 15'h0800, 15'h0ED8, 15'h6A00, 15'h1601, 15'h3202};

  lfva_top #(.DEPTH(DEPTH)) dut_u (
    .CLK(clk), .RST_N(rst_n),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_ARADDR(araddr), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .BUFFER_ENABLE_PIN(buf_en), .PROCESSING_ENABLE_PIN(proc_en),
    .VIDEO_DECODE_SELECT_PIN(vid_sel), .ASI_SELECT_PIN(asi_sel),
    .RD_CLK(rd_clk), .RD_RESET_N(rd_reset_n),
    .WR_VALID(wr_valid), .WR_LINE_START(wr_start), .WR_WORD(wr_word),
    .STUFFING_SYNC_FLAG(sync_flag), .CODE_WORD_ERROR_FLAG(err_flag),
    .RD_WORD(rd_word), .FIFO_EMPTY(empty), .FIFO_FULL(full)
  );

  lfva_reader u_rd (.rd_clk(rd_clk), .rd_reset_n(rd_reset_n));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  task automatic step(inout int n);
    @(posedge clk);
    n++;
    if (n > 200) begin
      errors++;
      $display("Timeout at %0t", $time);
      test_done();
    end
  endtask : step

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
    bit aw, w;
    int n;
    aw = 0;
    w = 0;
    n = 0;
    @(posedge clk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= v; bready <= 1'b1;
    while (!(aw && w)) begin
      step(n);
      if (!aw && awready) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (!w && wready) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    do step(n); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check(32'(bresp), 32'(lfva_pkg::RESP_OKAY));
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    do step(n); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do step(n); while (rvalid !== 1'b1);
    v = rdata;
    check(32'(rresp), 32'(lfva_pkg::RESP_OKAY));
    rready <= 1'b0;
  endtask : axi_rd

  task automatic wr(input logic [14:0] e, input logic st, input logic sy, input logic er);
    @(posedge clk);
    wr_valid <= 1'b1; wr_word <= e; wr_start <= st; sync_flag <= sy; err_flag <= er;
    @(posedge clk);
    wr_valid <= 1'b0; wr_start <= 1'b0; sync_flag <= 1'b0;
  endtask : wr

  task automatic rd(input int n);
    u_rd.pulse(n);
    repeat (2) @(posedge clk);
  endtask : rd

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_bypass();
    axi_rd(lfva_pkg::ADDR_CTRL, d);
    check(32'(d[1:0]), 32'(lfva_pkg::MODE_RST));
    wr(15'h35A3, 1'b0, 1'b0, 1'b0);
    @(posedge clk);
    #1 check(32'(rd_word), 32'h35A3);
    $display("Done: bypass");
  endtask : t_bypass

  task automatic t_modes();
    buf_en <= 1'b1;
    repeat (8) @(posedge clk);
    for (int m = 0; m < 4; m++) begin
      axi_wr(lfva_pkg::ADDR_CTRL, 32'(m));
      axi_rd(lfva_pkg::ADDR_CTRL, d);
      check(32'(d[1:0]), 32'(m));
      axi_rd(lfva_pkg::ADDR_STAT, d);
      check(32'(d[lfva_pkg::STAT_BUF]), 32'(m == 1));
    end
    $display("Done: modes");
  endtask : t_modes

  task automatic t_asi();
    int n;
    asi_sel <= 1'b1;
    repeat (10) @(posedge clk);
    axi_rd(lfva_pkg::ADDR_STAT, d);
    check(32'(d[5:4]), 32'(lfva_pkg::MODE_ASI));
    axi_wr(lfva_pkg::ADDR_FOFF, 32'h1);
    check(32'(empty), 32'h1);
    n = 0;
    for (int j = 0; j < 6; j++) begin
      if (j == 3) wr(15'h00FF, 1'b0, 1'b1, 1'b0);
      else begin
        wr(15'(8'hA0 + n), 1'b0, 1'b0, n[0]);
        n++;
      end
      if (j == 0) begin
        repeat (3) @(posedge clk);
        check(32'(empty), 32'h0);
      end
    end
    axi_wr(lfva_pkg::ADDR_EOFF, 32'h2);
    u_rd.rst_pulse();
    for (int k = 0; k < 5; k++) begin
      rd(1);
      check(32'({rd_word[14:13], rd_word[7:0]}), 32'({1'b0, k[0], 8'(8'hA0 + k)}));
    end
    check(32'(empty), 32'h1);
    for (int k = 0; k < 3; k++) begin
      wr(15'h0011, 1'b0, 1'b0, 1'b0);
      repeat (3) @(posedge clk);
      check(32'(empty), 32'(k < 2));
    end
    for (int k = 0; k < DEPTH - 3; k++) wr(15'h0022, 1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    check(32'(full), 32'h1);
    rd(1);
    check(32'(full), 32'h1);
    rd(1);
    check(32'(full), 32'h0);
    $display("Done: asi");
  endtask : t_asi

  task automatic t_video();
    vid_sel <= 1'b1;
    asi_sel <= 1'b0;
    proc_en <= 1'b1;
    repeat (10) @(posedge clk);
    axi_rd(lfva_pkg::ADDR_STAT, d);
    check(32'(d[5:4]), 32'(lfva_pkg::MODE_VIDEO));
    // Fill addresses 0..DEPTH-4 so the start words land just below zero
    for (int i = 0; i < DEPTH - 3; i++) wr(15'h0123, i == 0, 1'b0, 1'b0);
    for (int i = 0; i < 6; i++) wr(seq[i], i == 3, 1'b0, 1'b0);
    u_rd.rst_pulse();
    rd(1);
    check(32'(rd_word), 32'(seq[0]));
    for (int i = 1; i < 6; i++) begin
      rd(1);
      check(32'(rd_word), 32'(seq[i]));
    end
    $display("Done: video");
  endtask : t_video

  initial begin
    errors = 0;
    check_count = 0;
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0; araddr = '0; wdata = '0; wstrb = 4'hF;
    {buf_en, proc_en, vid_sel, asi_sel} = '0;
    {wr_valid, wr_start, sync_flag, err_flag} = '0;
    wr_word = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    t_bypass();
    t_modes();
    t_asi();
    t_video();
    test_done();
  end
endmodule : lfva_top_tb

`default_nettype wire
